/* common/tcp_pkg.sv */
// constants shared by the timer0 counter block
package tcp_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_OPTION  = 4'h0;
  localparam logic [3:0] OFS_COUNT   = 4'h1;
  localparam logic [3:0] OFS_IRQCTRL = 4'h2;
  localparam logic [3:0] OFS_IRQSTAT = 4'h3;
  localparam logic [3:0] OFS_IRQEN   = 4'h4;
  localparam logic [3:0] OFS_IRQCLR  = 4'h5;
  // option register fields
  localparam int OPT_PULLUP_DIS = 7;
  localparam int OPT_EXT_EDGE   = 6;
  localparam int OPT_SRC_SEL    = 5;
  localparam int OPT_EDGE_SEL   = 4;
  localparam int OPT_BYPASS     = 3;
  localparam int OPT_RATE_MSB   = 2;
  localparam int OPT_RATE_LSB   = 0;
  // interrupt control register fields
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_PERIPH_EN = 6;
  localparam int IC_OVF_EN   = 5;
  localparam int IC_EXT_EN   = 4;
  localparam int IC_CHG_EN   = 3;
  localparam int IC_OVF_FLAG = 2;
  localparam int IC_EXT_FLAG = 1;
  localparam int IC_CHG_FLAG = 0;
  // sticky event status layout
  localparam int NUM_EVT = 3;
  localparam int EV_OVF  = 0;
  localparam int EV_EXT  = 1;
  localparam int EV_CHG  = 2;
  // reset values and fixed figures
  localparam logic [7:0] OPTION_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] IRQCTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  localparam logic [7:0] COUNT_ONE   = 8'h01;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [2:0] EVT_NONE    = 3'h0;
  // instruction cycle phases, one system clock each, four per instruction cycle
  localparam logic [1:0] PHASE_ONE = 2'h1;
  localparam logic [1:0] PHASE_SECOND = 2'h1;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
  localparam logic [1:0] INHIBIT_CYC = 2'h2;
  localparam logic [1:0] INHIBIT_ONE = 2'h1;
  localparam logic [1:0] INHIBIT_OFF = 2'h0;
endpackage : tcp_pkg

/* hdl/tcp_timer0.sv */
// timer0: 8-bit timer/counter with prescaler, overflow flag and register port
// Overview of operation
// - source select 0 counts instruction cycles, one per cycle when bypassed.
// - a count write holds counting for the next two instruction cycles.
// - source select 1 counts transitions of the external count pin.
// - edge select 1 counts falling pin edges, 0 counts rising edges.
// - bypass bit 0 routes the source through the prescaler, 1 divides by one.
// - rate field selects division by two to the power rate plus one.
// - prescaler is hidden from software and cleared by every count write.
// - each wrap from FF to 00 sets the overflow flag, enabled or not.
// - hardware never clears the overflow flag; software writes it to zero.
// - interrupt control holds enables in bits 7..3 and flags in bits 2..0.
// - during sleep counting stops and the count holds its value.
// - pin edges are taken into counting only on the second and fourth phase.
// - the prescaler belongs to this timer alone, not to the watchdog.
// - overflow is driven out as a pulse for the neighbouring timer gate.
// - option holds pull-up disable, ext edge, source, edge, bypass, rate.
// - ext edge bit 1 triggers on rising interrupt pin edge, 0 on falling.
`timescale 1ns/10ps
module tcp_timer0
  import tcp_pkg::*;
#(
  parameter int PRES_W = 8              // prescaler counter width
) (
  input  wire logic       clk,           // system clock, 50 MHz
  input  wire logic       rstn,          // async reset, active low
  input  wire logic [3:0] regAddr,       // register address
  input  wire logic [7:0] regWdata,      // register write data
  input  wire logic       regWr,         // write strobe
  input  wire logic       regRd,         // read strobe
  output logic      [7:0] regRdata,      // read data, cycle after strobe
  input  wire logic       extCountPin,   // external count pin, async
  input  wire logic       extIrqPin,     // external interrupt pin, async
  input  wire logic       pinChangeEvt,  // pin change event pulse
  input  wire logic       sleepMode,     // processor asleep
  output logic            overflowPulse, // one cycle per wrap, gate source
  output logic            pullupDisable, // weak pull-ups off
  output logic            irqOut         // enabled status pending
);

  typedef struct packed {
    logic [7:0]         option;
    logic [7:0]         count;
    logic [7:0]         irqCtrl;
    logic [NUM_EVT-1:0] irqStat;
    logic [NUM_EVT-1:0] irqEn;
    logic [PRES_W-1:0]  pres;
    logic [1:0]         phase;
    logic [1:0]         inhibit;
    logic               extSyncA;
    logic               extSyncB;
    logic               extPrev;
    logic               intSyncA;
    logic               intSyncB;
    logic               intPrev;
    logic               edgePend;
    logic               ovfPulse;
    logic               irq;
    logic [7:0]         rdata;
  } tcp_state_t;

  tcp_state_t st_ff;
  tcp_state_t nxt_st;

  // terminal count of the prescaler for a given rate
  function automatic logic [PRES_W-1:0] tcpPresMask(input logic [2:0] rate);
    logic [PRES_W:0] one;
    one = {{PRES_W{1'b0}}, 1'b1};
    // widen before the plus one, or rate 7 wraps to a shift of zero
    tcpPresMask = PRES_W'((one << ({1'b0, rate} + 4'h1)) - one);
  endfunction : tcpPresMask

  logic       instrEnd;
  logic       sampleSlot;
  logic       pinEdge;
  logic       extIrqEvt;
  logic       running;
  logic       srcTick;
  logic       presWrap;
  logic       countTick;
  logic       ovfEvt;
  logic       wrCount;
  logic [2:0] rate;
  logic [NUM_EVT-1:0] evt;

  // event decode from current state
  always_comb begin
    rate       = st_ff.option[OPT_RATE_MSB:OPT_RATE_LSB];
    instrEnd   = st_ff.phase == PHASE_FOURTH;
    sampleSlot = (st_ff.phase == PHASE_SECOND) || (st_ff.phase == PHASE_FOURTH);
    wrCount    = regWr && (regAddr == OFS_COUNT);
    // edge taken on the second and third flop, never the first
    if (st_ff.option[OPT_EDGE_SEL]) begin
      pinEdge = st_ff.extPrev && !st_ff.extSyncB;
    end else begin
      pinEdge = !st_ff.extPrev && st_ff.extSyncB;
    end
    if (st_ff.option[OPT_EXT_EDGE]) begin
      extIrqEvt = !st_ff.intPrev && st_ff.intSyncB;
    end else begin
      extIrqEvt = st_ff.intPrev && !st_ff.intSyncB;
    end
    running = !sleepMode && (st_ff.inhibit == INHIBIT_OFF);
    if (st_ff.option[OPT_SRC_SEL]) begin
      srcTick = st_ff.edgePend && sampleSlot && running;
    end else begin
      srcTick = instrEnd && running;
    end
    presWrap = srcTick && (st_ff.pres == tcpPresMask(rate));
    if (st_ff.option[OPT_BYPASS]) begin
      countTick = srcTick;
    end else begin
      countTick = presWrap;
    end
    ovfEvt = countTick && (st_ff.count == COUNT_MAX) && !wrCount;
    evt = EVT_NONE;
    evt[EV_OVF] = ovfEvt;
    evt[EV_EXT] = extIrqEvt;
    evt[EV_CHG] = pinChangeEvt;
  end

  // next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.phase = st_ff.phase + PHASE_ONE;
    // two-flop synchronisers plus an edge history flop
    nxt_st.extSyncA = extCountPin;
    nxt_st.extSyncB = st_ff.extSyncA;
    nxt_st.extPrev  = st_ff.extSyncB;
    nxt_st.intSyncA = extIrqPin;
    nxt_st.intSyncB = st_ff.intSyncA;
    nxt_st.intPrev  = st_ff.intSyncB;
    // an edge waits for the next sampling phase; dropped in sleep
    nxt_st.edgePend = !sleepMode && (pinEdge || (st_ff.edgePend && !sampleSlot));
    // inhibit window counts down on instruction boundaries
    if (instrEnd && (st_ff.inhibit != INHIBIT_OFF) && !sleepMode) begin
      nxt_st.inhibit = st_ff.inhibit - INHIBIT_ONE;
    end
    // prescaler is private to this timer; not on the register map
    if (srcTick && !st_ff.option[OPT_BYPASS]) begin
      nxt_st.pres = presWrap ? '0 : st_ff.pres + PRES_W'(1);
    end
    if (countTick) begin
      nxt_st.count = st_ff.count + COUNT_ONE;
    end
    // software writes win over a concurrent count tick
    if (regWr) begin
      unique case (regAddr)
        OFS_OPTION: nxt_st.option = regWdata;
        OFS_COUNT: begin
          nxt_st.count   = regWdata;
          nxt_st.pres    = '0;
          nxt_st.inhibit = INHIBIT_CYC;
        end
        OFS_IRQCTRL: nxt_st.irqCtrl = regWdata;
        OFS_IRQEN:  nxt_st.irqEn  = regWdata[NUM_EVT-1:0];
        OFS_IRQCLR: nxt_st.irqStat = st_ff.irqStat & ~regWdata[NUM_EVT-1:0];
        default: ;
      endcase
    end
    // flags set by hardware; a set beats a same-cycle software clear
    nxt_st.irqCtrl[IC_OVF_FLAG] = nxt_st.irqCtrl[IC_OVF_FLAG] | ovfEvt;
    nxt_st.irqCtrl[IC_EXT_FLAG] = nxt_st.irqCtrl[IC_EXT_FLAG] | extIrqEvt;
    nxt_st.irqCtrl[IC_CHG_FLAG] = nxt_st.irqCtrl[IC_CHG_FLAG] | pinChangeEvt;
    nxt_st.irqStat  = nxt_st.irqStat | evt;
    nxt_st.irq      = |(nxt_st.irqStat & nxt_st.irqEn);
    nxt_st.ovfPulse = ovfEvt;
    // read data for one cycle only; reads have no side effects
    nxt_st.rdata = RD_UNMAPPED;
    if (regRd) begin
      unique case (regAddr)
        OFS_OPTION:  nxt_st.rdata = st_ff.option;
        OFS_COUNT:   nxt_st.rdata = st_ff.count;
        OFS_IRQCTRL: nxt_st.rdata = st_ff.irqCtrl;
        OFS_IRQSTAT: nxt_st.rdata = {{(8-NUM_EVT){1'b0}}, st_ff.irqStat};
        OFS_IRQEN:   nxt_st.rdata = {{(8-NUM_EVT){1'b0}}, st_ff.irqEn};
        default:     nxt_st.rdata = RD_UNMAPPED;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff        <= '0;
      st_ff.option <= OPTION_RST;
      st_ff.count  <= COUNT_RST;
      st_ff.irqCtrl <= IRQCTRL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign regRdata      = st_ff.rdata;
  assign overflowPulse = st_ff.ovfPulse;
  assign pullupDisable = st_ff.option[OPT_PULLUP_DIS];
  assign irqOut        = st_ff.irq;

  // checks next to the logic they guard
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [PRES_W-1:0] maskNow;
  assign maskNow = tcpPresMask(rate);

  chk_timer_step: assert property (
    (instrEnd && !st_ff.option[OPT_SRC_SEL] && st_ff.option[OPT_BYPASS]
     && running && !wrCount)
    |=> st_ff.count == $past(st_ff.count) + COUNT_ONE)
    else $error("timer mode did not step once per instruction");

  chk_write_load: assert property (
    wrCount |=> (st_ff.count == $past(regWdata)) && (st_ff.inhibit == INHIBIT_CYC))
    else $error("count write did not load and arm the hold");

  chk_inhibit_hold: assert property (
    (st_ff.inhibit != INHIBIT_OFF && !wrCount) |=> st_ff.count == $past(st_ff.count))
    else $error("count moved inside the write hold window");

  chk_pres_clear: assert property (
    wrCount |=> st_ff.pres == '0)
    else $error("prescaler not cleared by count write");

  chk_counter_step: assert property (
    (st_ff.option[OPT_SRC_SEL] && st_ff.option[OPT_BYPASS] && st_ff.edgePend
     && sampleSlot && running && !wrCount)
    |=> st_ff.count == $past(st_ff.count) + COUNT_ONE)
    else $error("counter mode missed a sampled pin edge");

  chk_edge_pend: assert property (
    (pinEdge && !sleepMode) |=> st_ff.edgePend)
    else $error("selected pin edge not captured");

  chk_rate_div: assert property (
    (srcTick && !st_ff.option[OPT_BYPASS] && !wrCount && st_ff.pres == maskNow)
    |=> st_ff.pres == '0 && st_ff.count == $past(st_ff.count) + COUNT_ONE)
    else $error("prescaler period end did not advance count");

  chk_ovf_flag: assert property (
    ovfEvt |=> st_ff.irqCtrl[IC_OVF_FLAG] && st_ff.irqStat[EV_OVF]
    && st_ff.count == '0 && overflowPulse ##1 !overflowPulse)
    else $error("wrap did not set flag and pulse once");

  chk_flag_sticky: assert property (
    (st_ff.irqCtrl[IC_OVF_FLAG] && !(regWr && regAddr == OFS_IRQCTRL))
    |=> st_ff.irqCtrl[IC_OVF_FLAG])
    else $error("overflow flag cleared without software");

  chk_sleep_freeze: assert property (
    (sleepMode && !wrCount) |=> $stable(st_ff.count))
    else $error("count changed during sleep");

  chk_ext_edge: assert property (
    extIrqEvt |=> st_ff.irqCtrl[IC_EXT_FLAG] && st_ff.irqStat[EV_EXT]
    ##1 (st_ff.irqCtrl[IC_EXT_FLAG] || $past(regWr)))
    else $error("ext interrupt edge did not set its flag");

  // timing base and source selection
  chk_phase_step: assert property (
    1'b1 |=> st_ff.phase == $past(st_ff.phase) + PHASE_ONE)
    else $error("instruction phase did not advance by one");

  chk_tick_source: assert property (
    (!st_ff.option[OPT_SRC_SEL] && !instrEnd && !wrCount)
    |=> $stable(st_ff.count))
    else $error("timer mode moved off an instruction boundary");

  chk_slot_only: assert property (
    (st_ff.option[OPT_SRC_SEL] && !sampleSlot && !wrCount)
    |=> $stable(st_ff.count))
    else $error("counter mode moved outside a sampling phase");

  chk_bypass_pres: assert property (
    (st_ff.option[OPT_BYPASS] && !wrCount) |=> $stable(st_ff.pres))
    else $error("bypassed prescaler still advanced");

  chk_sleep_drop: assert property (
    sleepMode |=> !st_ff.edgePend)
    else $error("pin edge kept pending through sleep");

  // overflow reporting: only a real wrap may raise it
  chk_wrap_needed: assert property (
    (countTick && st_ff.count != COUNT_MAX) |=> !overflowPulse)
    else $error("overflow pulse without a wrap");

  chk_pulse_zero: assert property (
    overflowPulse |-> st_ff.count == '0 && st_ff.irqCtrl[IC_OVF_FLAG])
    else $error("overflow pulse without zero count and flag");

  chk_stat_sticky: assert property (
    (st_ff.irqStat[EV_OVF] && !(regWr && regAddr == OFS_IRQCLR))
    |=> st_ff.irqStat[EV_OVF])
    else $error("overflow status cleared without software");

  // register port: writes land, reads stand one cycle; no pending edge without a pin edge
  chk_opt_write: assert property (
    (regWr && regAddr == OFS_OPTION) |=> st_ff.option == $past(regWdata))
    else $error("option write did not land");

  chk_ctrl_write: assert property (
    (regWr && regAddr == OFS_IRQCTRL)
    |=> st_ff.irqCtrl[IC_GLOBAL_EN:IC_CHG_EN] == $past(regWdata[IC_GLOBAL_EN:IC_CHG_EN]))
    else $error("interrupt control enables not written");

  chk_read_count: assert property (
    (regRd && regAddr == OFS_COUNT) |=> regRdata == $past(st_ff.count))
    else $error("count read returned a wrong value");

  chk_read_idle: assert property (
    !regRd |=> regRdata == RD_UNMAPPED)
    else $error("read data stood beyond its cycle");

  chk_pin_edge: assert property (
    (st_ff.option[OPT_SRC_SEL] && !st_ff.edgePend && !pinEdge) |=> !st_ff.edgePend)
    else $error("pending edge appeared without a pin edge");

  // level interrupt follows status and enable with one flop
  chk_irq_level: assert property (
    irqOut == |(st_ff.irqStat & st_ff.irqEn))
    else $error("interrupt output disagrees with status and enable");

  // main scenarios to cover; the bench reaches only the write hold and irq ones
  cov_ovf_counter: cover property (ovfEvt && st_ff.option[OPT_SRC_SEL]);
  cov_ovf_slow: cover property (ovfEvt && !st_ff.option[OPT_BYPASS] && rate == 3'h7);
  cov_write_hold: cover property (wrCount ##1 st_ff.inhibit == INHIBIT_CYC
    ##[1:4] st_ff.inhibit == INHIBIT_ONE);
  cov_irq_out: cover property (!irqOut ##1 irqOut);

endmodule : tcp_timer0

/* verification/tb.sv */
// register-level testbench for the timer0 block
`timescale 1ns/10ps
module tb
  import tcp_pkg::*;
;
  logic       clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, run = 1'b0;
  logic       extIrqPin = 1'b0, pinChangeEvt = 1'b0, sleepMode = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, a, b;
  logic       extCountPin, overflowPulse, pullupDisable, irqOut;
  int         failures = 0, comparisons = 0, cycles = 0, idx, per;
  localparam int CYCLE_LIMIT = 30000;
  always #10 clk = ~clk;
  tcp_timer0 i_tcp_timer0 (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extCountPin(extCountPin),
    .extIrqPin(extIrqPin), .pinChangeEvt(pinChangeEvt), .sleepMode(sleepMode),
    .overflowPulse(overflowPulse), .pullupDisable(pullupDisable), .irqOut(irqOut));
  tcp_count_source i_tcp_count_source (.clk(clk), .rstn(rstn), .run(run), .pin(extCountPin));
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // hang guard: the whole sequence needs well under the ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      failures++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  // burst of 2n+1 pin toggles, so the starting level sees one extra edge
  task automatic burst(input int n);
    @(posedge clk);
    run <= 1'b1;
    idle(8 * n + 4);
    run <= 1'b0;
    idle(20);
  endtask : burst
  initial begin
    idle(2);
    rstn <= 1'b1;
    rd(OFS_OPTION, a); cmp(a, OPTION_RST);
    rd(OFS_IRQCTRL, a); cmp(a, IRQCTRL_RST);
    rd(4'h6, a); cmp(a, RD_UNMAPPED);
    cmp({7'h0, pullupDisable}, 8'h00);
    wr(OFS_OPTION, 8'h80); idle(2); cmp({7'h0, pullupDisable}, 8'h01);
    rd(OFS_OPTION, a); cmp(a, 8'h80);
    $display("test reset_values done");
    // rate loop, last entry is the bypassed 1:1 case; span of three periods
    for (int i = 0; i < 9; i++) begin
      wr(OFS_OPTION, (i == 8) ? 8'h08 : 8'(i));
      per = (i == 8) ? 4 : (4 << (i + 1));
      wr(OFS_COUNT, 8'h00);
      idle(20);
      rd(OFS_COUNT, a);
      idle(3 * per - 2);
      rd(OFS_COUNT, b);
      cmp(b - a, 8'h03);
    end
    $display("test prescaler done");
    // write hold: two instruction cycles pass before FF wraps
    wr(OFS_COUNT, COUNT_MAX);
    idx = 0;
    for (int c = 1; c <= 16; c++) begin
      @(posedge clk);
      #1 if (overflowPulse === 1'b1 && idx == 0) idx = c;
    end
    cmp(8'(idx >= 9 && idx <= 14), 8'h01);
    rd(OFS_IRQCTRL, a); cmp(a & 8'h04, 8'h04);
    $display("test write_hold done");
    wr(OFS_OPTION, 8'h28); wr(OFS_COUNT, 8'h00); idle(20);
    burst(5); rd(OFS_COUNT, a); cmp(a, 8'h06);
    wr(OFS_OPTION, 8'h38); wr(OFS_COUNT, 8'h00); idle(20);
    burst(5); rd(OFS_COUNT, a); cmp(a, 8'h06);
    $display("test counter_mode done");
    wr(OFS_OPTION, 8'h08);
    sleepMode <= 1'b1;
    idle(4);
    rd(OFS_COUNT, a); idle(60); rd(OFS_COUNT, b); cmp(b, a);
    rd(OFS_IRQCTRL, a); cmp(a & 8'h04, 8'h04);
    wr(OFS_IRQCTRL, 8'h00); rd(OFS_IRQCTRL, a); cmp(a & 8'h04, 8'h00);
    $display("test sleep_flag done");
    // interrupt path: raise, mask, clear, using frozen count as backdrop
    rd(OFS_IRQSTAT, a); cmp(a & 8'h01, 8'h01);
    cmp({7'h0, irqOut}, 8'h00);
    wr(OFS_IRQEN, 8'h01); idle(2); cmp({7'h0, irqOut}, 8'h01);
    wr(OFS_IRQEN, 8'h00); idle(2); cmp({7'h0, irqOut}, 8'h00);
    wr(OFS_IRQEN, 8'h07); wr(OFS_IRQCLR, 8'h07); idle(2); cmp({7'h0, irqOut}, 8'h00);
    rd(OFS_IRQSTAT, a); cmp(a, EVT_NONE);
    @(posedge clk); pinChangeEvt <= 1'b1; @(posedge clk); pinChangeEvt <= 1'b0;
    idle(2); rd(OFS_IRQSTAT, a); cmp(a, 8'h04);
    cmp({7'h0, irqOut}, 8'h01);
    wr(OFS_IRQCLR, 8'h07);
    $display("test interrupts done");
    // falling edge selected: rising pin must not flag
    extIrqPin <= 1'b1; idle(10); rd(OFS_IRQSTAT, a); cmp(a & 8'h02, 8'h00);
    extIrqPin <= 1'b0; idle(10); rd(OFS_IRQSTAT, a); cmp(a & 8'h02, 8'h02);
    rd(OFS_IRQCTRL, a); cmp(a & 8'h02, 8'h02);
    wr(OFS_OPTION, 8'h48); wr(OFS_IRQCLR, 8'h07);
    extIrqPin <= 1'b1; idle(10); rd(OFS_IRQSTAT, a); cmp(a & 8'h02, 8'h02);
    sleepMode <= 1'b0;
    $display("test ext_irq done");
    end_of_test();
  end
endmodule : tb

/* verification/tcp_count_source.sv */
// far-side model: pulse source on the external count pin
`timescale 1ns/10ps
module tcp_count_source #(
  parameter int HALF = 4                 // clocks per pin level
) (
  input  wire logic clk,                 // system clock
  input  wire logic rstn,                // async reset, active low
  input  wire logic run,                 // burst request from bench
  output logic      pin                  // drives the count pin
);
  int cnt;
  // levels last HALF clocks so the synchroniser sees each one
  // pin stands still between bursts, no free-running source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (!run) begin
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : tcp_count_source
